/* core/stack_bridge_defs.svh */
// Constants of the expansion stack bridge
`ifndef STACK_BRIDGE_DEFS_SVH
`define STACK_BRIDGE_DEFS_SVH

// Expansion window, whole processor address
`define WIN_LO 32'h1000_0000
`define WIN_HI 32'h1fff_ffff
// Address field positions
`define SA_MSB 19
`define LA_MSB 23
`define LA_LSB 17
`define ADDR_MSB 23
`define DATA_MSB 15
// Stack clock: 14.7456 MHz made from the link clock by fractional accumulation
`define SYSCLK_KHZ_X10 147456
`define LINK_KHZ_X10 1666667
`define ACC_W 22
// Reset value of the stack reset output while the processor is in reset
`define STACK_RST_ON 1'b1

`endif

/* core/stack_bridge_pkg.sv */
// Types of the expansion stack bridge
package stack_bridge_pkg;
    typedef logic [15:0] data_t;
    typedef logic [31:0] addr_t;
    typedef logic [21:0] acc_t;
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_s;
    typedef struct packed {
        logic r1;
        logic r2;
    } rst_sync_s;
    typedef struct packed {
        acc_t acc;
        logic clk_out;
        logic rst_meta;
        logic rst_link;
    } clkgen_s;
endpackage

/* core/level_sync.sv */
// Two flip-flop synchroniser for a single level
`timescale 1ns/100ps
module level_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level
    input wire logic din,
    output logic dout
);
    import stack_bridge_pkg::*;

    sync_s q;
    sync_s next_q;

    always_comb begin
        next_q.s1 = din;
        next_q.s2 = q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.s2;
endmodule // level_sync

/* core/stack_clock_gen.sv */
// Free-running stack clock generator on the link clock
`timescale 1ns/100ps
`include "stack_bridge_defs.svh"
module stack_clock_gen (
    // Link clock and reset from the main domain
    input wire logic link_clk,
    input wire logic rst_n,
    // Stack clock
    output logic stack_clk
);
    import stack_bridge_pkg::*;

    localparam acc_t STEP = acc_t'((longint'(`SYSCLK_KHZ_X10) * (2 ** `ACC_W)) / `LINK_KHZ_X10);

    clkgen_s q;
    clkgen_s next_q;

    always_comb begin
        next_q = q;
        next_q.rst_meta = 1'b1;
        next_q.rst_link = q.rst_meta;
        // MSB of the phase accumulator is the clock
        next_q.acc = q.rst_link ? acc_t'(q.acc + STEP) : '0;
        next_q.clk_out = q.acc[`ACC_W-1];
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign stack_clk = q.clk_out;
endmodule // stack_clock_gen

/* core/stack_bridge.sv */
// Expansion stack bridge: window decode, strobe gating, fixed controls, stack clock
`timescale 1ns/100ps
`include "stack_bridge_defs.svh"
module stack_bridge (
    // Clocks and reset
    input wire logic REF_CLK,
    input wire logic LINK_CLK,
    input wire logic RSTN,
    // Processor bus
    input wire stack_bridge_pkg::addr_t CPU_ADDRESS_BUS,
    input wire logic CPU_WRITE_STROBE_N,
    input wire logic CPU_READ_STROBE_N,
    output logic CPU_WAIT_IN_N,
    input wire stack_bridge_pkg::data_t CPU_DATA_OUT,
    input wire logic CPU_DATA_OE,
    output stack_bridge_pkg::data_t CPU_DATA_IN,
    // Processor interrupts and general I/O
    output logic [2:0] CPU_INT,
    input wire logic GENERAL_IO_BIT_TWELVE_OUT,
    input wire logic GENERAL_IO_BIT_TWELVE_OE,
    output logic GENERAL_IO_BIT_TWELVE_IN,
    // Stack data
    input wire stack_bridge_pkg::data_t STACK_DATA_IN,
    output stack_bridge_pkg::data_t STACK_DATA_OUT,
    output logic STACK_DATA_OE,
    // Stack address and strobes
    output logic [19:0] STACK_SYS_ADDR,
    output logic [6:0] STACK_LATCH_ADDR,
    output logic STACK_ADDR_LATCH_N,
    output logic STACK_IO_WRITE_N,
    output logic STACK_IO_READ_N,
    output logic STACK_MEM_WRITE_N,
    output logic STACK_MEM_READ_N,
    output logic STACK_SMEM_WRITE_N,
    output logic STACK_SMEM_READ_N,
    output logic STACK_BYTE_HIGH_N,
    output logic STACK_ADDR_ENABLE,
    // Stack returns
    input wire logic STACK_CHANNEL_READY,
    input wire logic [2:0] STACK_IRQ,
    input wire logic STACK_TC_IN,
    output logic STACK_TC_OUT,
    output logic STACK_TC_OE,
    // Stack reset and clock
    output logic STACK_RESET,
    output logic STACK_SYSCLK
);
    import stack_bridge_pkg::*;

    rst_sync_s q;
    rst_sync_s next_q;
    logic rst_n;
    logic link_rst_n;
    logic in_window;

    function automatic logic window_hit(input addr_t a);
        window_hit = (a >= `WIN_LO) && (a <= `WIN_HI);
    endfunction

    // Outside the window a strobe is parked at its idle level
    function automatic logic gate_strobe(input logic hit, input logic strobe_n);
        gate_strobe = hit ? strobe_n : 1'b1;
    endfunction

    // Reset release through two flip-flops
    always_comb begin
        next_q.r1 = 1'b1;
        next_q.r2 = q.r1;
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rst_n = q.r2;

    // Stack reset follows processor reset
    assign STACK_RESET = rst_n ? ~`STACK_RST_ON : `STACK_RST_ON;

    // Window decode with no clock in the path
    assign in_window = window_hit(CPU_ADDRESS_BUS);
    assign STACK_ADDR_LATCH_N = ~in_window;
    assign STACK_IO_WRITE_N = gate_strobe(in_window, CPU_WRITE_STROBE_N);
    assign STACK_IO_READ_N = gate_strobe(in_window, CPU_READ_STROBE_N);

    // Fixed controls
    assign STACK_ADDR_ENABLE = 1'b0;
    assign STACK_MEM_WRITE_N = 1'b1;
    assign STACK_MEM_READ_N = 1'b1;
    assign STACK_SMEM_WRITE_N = 1'b1;
    assign STACK_SMEM_READ_N = 1'b1;
    assign STACK_BYTE_HIGH_N = 1'b1;

    // Data toward the stack, bit for bit
    always_comb begin
        // Low byte
        STACK_DATA_OUT[0] = CPU_DATA_OUT[0];
        STACK_DATA_OUT[1] = CPU_DATA_OUT[1];
        STACK_DATA_OUT[2] = CPU_DATA_OUT[2];
        STACK_DATA_OUT[3] = CPU_DATA_OUT[3];
        STACK_DATA_OUT[4] = CPU_DATA_OUT[4];
        STACK_DATA_OUT[5] = CPU_DATA_OUT[5];
        STACK_DATA_OUT[6] = CPU_DATA_OUT[6];
        STACK_DATA_OUT[7] = CPU_DATA_OUT[7];
        // High byte
        STACK_DATA_OUT[8] = CPU_DATA_OUT[8];
        STACK_DATA_OUT[9] = CPU_DATA_OUT[9];
        STACK_DATA_OUT[10] = CPU_DATA_OUT[10];
        STACK_DATA_OUT[11] = CPU_DATA_OUT[11];
        STACK_DATA_OUT[12] = CPU_DATA_OUT[12];
        STACK_DATA_OUT[13] = CPU_DATA_OUT[13];
        STACK_DATA_OUT[14] = CPU_DATA_OUT[14];
        STACK_DATA_OUT[15] = CPU_DATA_OUT[15];
    end

    // The stack side is driven only while the processor drives its data
    assign STACK_DATA_OE = CPU_DATA_OE;

    // Data toward the processor, bit for bit
    always_comb begin
        // Low byte
        CPU_DATA_IN[0] = STACK_DATA_IN[0];
        CPU_DATA_IN[1] = STACK_DATA_IN[1];
        CPU_DATA_IN[2] = STACK_DATA_IN[2];
        CPU_DATA_IN[3] = STACK_DATA_IN[3];
        CPU_DATA_IN[4] = STACK_DATA_IN[4];
        CPU_DATA_IN[5] = STACK_DATA_IN[5];
        CPU_DATA_IN[6] = STACK_DATA_IN[6];
        CPU_DATA_IN[7] = STACK_DATA_IN[7];
        // High byte
        CPU_DATA_IN[8] = STACK_DATA_IN[8];
        CPU_DATA_IN[9] = STACK_DATA_IN[9];
        CPU_DATA_IN[10] = STACK_DATA_IN[10];
        CPU_DATA_IN[11] = STACK_DATA_IN[11];
        CPU_DATA_IN[12] = STACK_DATA_IN[12];
        CPU_DATA_IN[13] = STACK_DATA_IN[13];
        CPU_DATA_IN[14] = STACK_DATA_IN[14];
        CPU_DATA_IN[15] = STACK_DATA_IN[15];
    end

    // System address lines carry the low address bits unchanged
    always_comb begin
        // Bits 7..0
        STACK_SYS_ADDR[0] = CPU_ADDRESS_BUS[0];
        STACK_SYS_ADDR[1] = CPU_ADDRESS_BUS[1];
        STACK_SYS_ADDR[2] = CPU_ADDRESS_BUS[2];
        STACK_SYS_ADDR[3] = CPU_ADDRESS_BUS[3];
        STACK_SYS_ADDR[4] = CPU_ADDRESS_BUS[4];
        STACK_SYS_ADDR[5] = CPU_ADDRESS_BUS[5];
        STACK_SYS_ADDR[6] = CPU_ADDRESS_BUS[6];
        STACK_SYS_ADDR[7] = CPU_ADDRESS_BUS[7];
        // Bits 15..8
        STACK_SYS_ADDR[8] = CPU_ADDRESS_BUS[8];
        STACK_SYS_ADDR[9] = CPU_ADDRESS_BUS[9];
        STACK_SYS_ADDR[10] = CPU_ADDRESS_BUS[10];
        STACK_SYS_ADDR[11] = CPU_ADDRESS_BUS[11];
        STACK_SYS_ADDR[12] = CPU_ADDRESS_BUS[12];
        STACK_SYS_ADDR[13] = CPU_ADDRESS_BUS[13];
        STACK_SYS_ADDR[14] = CPU_ADDRESS_BUS[14];
        STACK_SYS_ADDR[15] = CPU_ADDRESS_BUS[15];
        // Bits 19..16
        STACK_SYS_ADDR[16] = CPU_ADDRESS_BUS[16];
        STACK_SYS_ADDR[17] = CPU_ADDRESS_BUS[17];
        STACK_SYS_ADDR[18] = CPU_ADDRESS_BUS[18];
        STACK_SYS_ADDR[`SA_MSB] = CPU_ADDRESS_BUS[`SA_MSB];
    end

    // Latched address lines carry the upper address bits unchanged
    always_comb begin
        STACK_LATCH_ADDR[0] = CPU_ADDRESS_BUS[`LA_LSB];
        STACK_LATCH_ADDR[1] = CPU_ADDRESS_BUS[`LA_LSB + 1];
        STACK_LATCH_ADDR[2] = CPU_ADDRESS_BUS[`LA_LSB + 2];
        STACK_LATCH_ADDR[3] = CPU_ADDRESS_BUS[`LA_LSB + 3];
        STACK_LATCH_ADDR[4] = CPU_ADDRESS_BUS[`LA_LSB + 4];
        STACK_LATCH_ADDR[5] = CPU_ADDRESS_BUS[`LA_LSB + 5];
        STACK_LATCH_ADDR[6] = CPU_ADDRESS_BUS[`LA_MSB];
    end

    // Cycle stretch from the stack goes straight to the wait input
    assign CPU_WAIT_IN_N = STACK_CHANNEL_READY;

    // Stack interrupt requests, lowest to lowest
    always_comb begin
        CPU_INT[0] = STACK_IRQ[0];
        CPU_INT[1] = STACK_IRQ[1];
        CPU_INT[2] = STACK_IRQ[2];
    end

    // Terminal count shares the general I/O pin in both directions
    assign STACK_TC_OUT = GENERAL_IO_BIT_TWELVE_OUT;
    assign STACK_TC_OE = GENERAL_IO_BIT_TWELVE_OE;
    assign GENERAL_IO_BIT_TWELVE_IN = STACK_TC_IN;

    // Reset reaches the link domain through its own two flip-flops
    level_sync u_link_rst (
        .clk(LINK_CLK),
        .rst_n(rst_n),
        .din(1'b1),
        .dout(link_rst_n)
    );

    // Stack clock on the link domain
    stack_clock_gen u_clk (
        .link_clk(LINK_CLK),
        .rst_n(link_rst_n),
        .stack_clk(STACK_SYSCLK)
    );
endmodule // stack_bridge

/* test/stack_card.sv */
// Behavioural expansion card on the stack side
`timescale 1ns/100ps
module stack_card (
    // Bench controls
    input wire logic stall,
    input wire logic [2:0] irq_req,
    input wire logic tc_lvl,
    input wire logic [15:0] rdata,
    // Stack side
    input wire logic io_read_n,
    output logic ready,
    output logic [2:0] irq,
    output logic tc,
    output logic [15:0] data
);
    assign ready = !stall;
    assign irq = irq_req;
    assign tc = tc_lvl;
    // Released bus shows inverted data
    assign data = io_read_n ? ~rdata : rdata;
endmodule // stack_card

/* test/stack_bridge_props.sv */
// Checker for the stack bridge ports
`timescale 1ns/100ps
module stack_bridge_props (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire stack_bridge_pkg::addr_t CPU_ADDRESS_BUS,
    input wire logic CPU_WRITE_STROBE_N,
    input wire logic CPU_READ_STROBE_N,
    input wire logic CPU_WAIT_IN_N,
    input wire logic STACK_CHANNEL_READY,
    input wire logic [19:0] STACK_SYS_ADDR,
    input wire logic [6:0] STACK_LATCH_ADDR,
    input wire logic STACK_ADDR_LATCH_N,
    input wire logic STACK_IO_WRITE_N,
    input wire logic STACK_IO_READ_N,
    input wire logic STACK_ADDR_ENABLE,
    input wire logic STACK_RESET,
    input wire logic STACK_SYSCLK
);
    logic in_win;
    assign in_win = CPU_ADDRESS_BUS >= 32'h1000_0000 && CPU_ADDRESS_BUS <= 32'h1fff_ffff;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    property p_latch; STACK_ADDR_LATCH_N == !in_win; endproperty
    a_latch: assert property (p_latch) else $error("latch strobe wrong");
    property p_pass;
        in_win |-> {STACK_IO_WRITE_N, STACK_IO_READ_N} == {CPU_WRITE_STROBE_N, CPU_READ_STROBE_N};
    endproperty
    a_pass: assert property (p_pass) else $error("strobe not passed");
    property p_block; !in_win |-> STACK_IO_WRITE_N && STACK_IO_READ_N; endproperty
    a_block: assert property (p_block) else $error("strobe leaked");
    property p_rst_on; disable iff (1'b0) !RSTN |-> STACK_RESET; endproperty
    a_rst_on: assert property (p_rst_on) else $error("stack reset low");
    property p_rst_off; $rose(RSTN) |-> STACK_RESET ##1 STACK_RESET ##1 !STACK_RESET; endproperty
    a_rst_off: assert property (p_rst_off) else $error("stack reset release");
    property p_clk; $fell(STACK_SYSCLK) |-> (!STACK_SYSCLK) [*2] ##[1:3] $rose(STACK_SYSCLK); endproperty
    a_clk: assert property (p_clk) else $error("stack clock period");
    property p_aen; STACK_ADDR_ENABLE == 1'b0; endproperty
    a_aen: assert property (p_aen) else $error("address enable high");
    property p_wait; CPU_WAIT_IN_N == STACK_CHANNEL_READY; endproperty
    a_wait: assert property (p_wait) else $error("wait not routed");
    property p_addr;
        {STACK_LATCH_ADDR, STACK_SYS_ADDR} == {CPU_ADDRESS_BUS[23:17], CPU_ADDRESS_BUS[19:0]};
    endproperty
    a_addr: assert property (p_addr) else $error("address lines wrong");
    c_wr: cover property (in_win && !CPU_WRITE_STROBE_N);
    c_rd_out: cover property (!in_win && !CPU_READ_STROBE_N);
    c_clk: cover property ($rose(STACK_SYSCLK));
endmodule // stack_bridge_props

/* test/test_stack_bridge.sv */
// Self-checking bench of the stack bridge
`timescale 1ns/100ps
module test_stack_bridge;
    import stack_bridge_pkg::*;
    logic REF_CLK = 0, LINK_CLK = 0, RSTN = 1, CPU_WRITE_STROBE_N = 1, CPU_READ_STROBE_N = 1, CPU_DATA_OE = 0;
    logic GENERAL_IO_BIT_TWELVE_OUT = 0, GENERAL_IO_BIT_TWELVE_OE = 0, stall = 0, tc_lvl = 0;
    addr_t CPU_ADDRESS_BUS = 0;
    data_t CPU_DATA_OUT = 0, rdata = 0, CPU_DATA_IN, STACK_DATA_IN, STACK_DATA_OUT;
    logic [2:0] irq_req = 0, CPU_INT, STACK_IRQ;
    logic [19:0] STACK_SYS_ADDR;
    logic [6:0] STACK_LATCH_ADDR;
    logic CPU_WAIT_IN_N, GENERAL_IO_BIT_TWELVE_IN, STACK_DATA_OE, STACK_ADDR_LATCH_N;
    logic STACK_IO_WRITE_N, STACK_IO_READ_N;
    logic STACK_MEM_WRITE_N, STACK_MEM_READ_N, STACK_SMEM_WRITE_N, STACK_SMEM_READ_N, STACK_BYTE_HIGH_N;
    logic STACK_ADDR_ENABLE, STACK_CHANNEL_READY, STACK_TC_IN, STACK_TC_OUT, STACK_TC_OE, STACK_RESET, STACK_SYSCLK;
    int bad_count = 0, total_checks = 0, cyc = 0, n = 0;
    stack_bridge uut (.*);
    stack_card card (.stall(stall), .irq_req(irq_req), .tc_lvl(tc_lvl), .rdata(rdata), .io_read_n(STACK_IO_READ_N),
        .ready(STACK_CHANNEL_READY), .irq(STACK_IRQ), .tc(STACK_TC_IN), .data(STACK_DATA_IN));
    initial forever #5 REF_CLK = ~REF_CLK;
    initial begin
        #1.3;
        forever #3 LINK_CLK = ~LINK_CLK;
    end
    always @(posedge STACK_SYSCLK) n++;
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_window();
        addr_t tbl [4] = '{32'h0fff_ffff, 32'h1000_0000, 32'h1fff_ffff, 32'h2000_0000};
        logic in_w;
        for (int i = 0; i < 16; i++) begin
            @(negedge REF_CLK);
            CPU_ADDRESS_BUS = tbl[i/4];
            {CPU_WRITE_STROBE_N, CPU_READ_STROBE_N} = 2'(i);
            in_w = (i / 4 == 1) || (i / 4 == 2);
            #1;
            chk("latch", !in_w, STACK_ADDR_LATCH_N);
            chk("io write", in_w ? CPU_WRITE_STROBE_N : 1'b1, STACK_IO_WRITE_N);
            chk("io read", in_w ? CPU_READ_STROBE_N : 1'b1, STACK_IO_READ_N);
        end
        $display("window test done");
    endtask
    task automatic t_route();
        @(negedge REF_CLK);
        CPU_ADDRESS_BUS = 32'h10ab_cdef;
        CPU_READ_STROBE_N = 0;
        for (int k = 0; k < 2; k++) begin
            @(negedge REF_CLK);
            CPU_DATA_OE = k[0];
            GENERAL_IO_BIT_TWELVE_OE = !k[0];
            CPU_DATA_OUT = k ? 16'ha5c3 : 16'h5a3c;
            rdata = k ? 16'h3c5a : 16'hc3a5;
            irq_req = k ? 3'h2 : 3'h5;
            stall = !k[0];
            tc_lvl = !k[0];
            GENERAL_IO_BIT_TWELVE_OUT = k[0];
            #1;
            chk("sys addr", 32'h000b_cdef, STACK_SYS_ADDR);
            chk("latch addr", 32'h55, STACK_LATCH_ADDR);
            chk("data to stack", CPU_DATA_OUT, STACK_DATA_OUT);
            chk("data oe", k[0], STACK_DATA_OE);
            chk("data to cpu", rdata, CPU_DATA_IN);
            chk("irq", irq_req, CPU_INT);
            chk("wait", !stall, CPU_WAIT_IN_N);
            chk("tc", {tc_lvl, GENERAL_IO_BIT_TWELVE_OUT, !k[0]},
                {GENERAL_IO_BIT_TWELVE_IN, STACK_TC_OUT, STACK_TC_OE});
            chk("fixed", 32'h3e, {STACK_MEM_WRITE_N, STACK_MEM_READ_N, STACK_SMEM_WRITE_N, STACK_SMEM_READ_N,
                STACK_BYTE_HIGH_N, STACK_ADDR_ENABLE});
        end
        @(negedge REF_CLK);
        CPU_READ_STROBE_N = 1;
        $display("routing test done");
    endtask
    task automatic t_reset();
        @(negedge REF_CLK);
        RSTN = 0;
        #1;
        chk("reset on", 1, STACK_RESET);
        @(negedge REF_CLK);
        RSTN = 1;
        @(negedge REF_CLK);
        chk("reset held", 1, STACK_RESET);
        @(negedge REF_CLK);
        chk("reset off", 0, STACK_RESET);
        $display("reset test done");
    endtask
    task automatic t_clock();
        int start_edges;
        repeat (20) @(negedge REF_CLK);
        start_edges = n;
        repeat (1000) @(negedge REF_CLK);
        chk("clock edges in 10 us", 1, (n - start_edges) >= 146 && (n - start_edges) <= 148);
        $display("clock test done");
    endtask
    initial begin
        // Assert reset before the first clock edge so no flop is sampled unknown
        #1;
        RSTN = 0;
        repeat (12) @(negedge REF_CLK);
        RSTN = 1;
        repeat (4) @(negedge REF_CLK);
        t_window();
        t_route();
        t_reset();
        t_clock();
        give_verdict();
    end
endmodule // test_stack_bridge
bind stack_bridge stack_bridge_props chkr (.*);
